// >>> design/pmsp_pkg.sv
// =====================================================================
// Shared constants for the management serial port, both ends.
package pmsp_pkg;
   localparam int          PREAMBLE_LEN  = 32;        // Ones needed to synchronise.
   localparam int          NUM_REGS      = 32;        // Register space size.
   localparam int          REG_W         = 16;        // Register width.
   localparam int          ADDR_W        = 5;         // Device and register address width.
   localparam int          FRAME_BITS    = 32;        // Start to last data bit.
   localparam logic [1:0]  START_CODE    = 2'h1;      // Start pattern zero then one.
   localparam logic [1:0]  OP_READ       = 2'h2;      // Read opcode one then zero.
   localparam logic [1:0]  OP_WRITE      = 2'h1;      // Write opcode zero then one.
   localparam logic [1:0]  TA_WRITE      = 2'h2;      // Write turnaround one then zero.
   localparam logic [4:0]  BMSTAT_ADDR   = 5'h01;     // Basic mode status register offset.
   localparam int          BMSTAT_PS_BIT = 6;         // Preamble suppression ability bit.
   localparam logic [15:0] BMSTAT_RESET  = 16'h7849;  // Basic mode status value, bit 6 set.
   localparam int          MDC_DIV       = 4;         // Host half period in mclk cycles.
   localparam int          CLK_MHZ       = 200;       // Local clock rate.
   localparam int          MDC_MAX_MHZ   = 25;        // Fastest management clock.
   localparam int          MDC_MIN_DIV   = (CLK_MHZ + 2 * MDC_MAX_MHZ - 1) / (2 * MDC_MAX_MHZ);
endpackage : pmsp_pkg

// >>> design/pmsp_if.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Two-wire management link: clock from host, shared open data line.
interface pmsp_if;
   logic mgmtClk;      // Management clock driven by the host.
   logic hostDataOut;  // Host data output.
   logic hostDataOe;   // Host output enable, high while driving.
   logic devDataOut;   // Device data output.
   logic devDataOe;    // Device output enable, high while driving.
   logic mgmtData;     // Resolved line level, pulled high when released.
   assign mgmtData = hostDataOe ? hostDataOut : (devDataOe ? devDataOut : 1'b1);
   modport host (output mgmtClk, output hostDataOut, output hostDataOe, input mgmtData);
   modport dev  (input mgmtClk, output devDataOut, output devDataOe, input mgmtData);
endinterface : pmsp_if
`default_nettype wire

// >>> design/pmsp_device.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Device end: synchronises, decodes frames, owns the register space.
module pmsp_device #(
   parameter logic [4:0] DEV_ADDR = 5'h01  // Own device address on the shared line.
) (
   input  wire logic mclk,                  // Local clock.
   input  wire logic rst_b,                 // Synchronous reset, active low.
   pmsp_if.dev       link,                  // Management link.
   output var  logic synced,                // Preamble seen and still in step.
   output var  logic [4:0]  wrAddr,         // Register address of last write.
   output var  logic [15:0] wrData,         // Data of last write.
   output var  logic wrStrobe               // One-cycle pulse per accepted write.
);
   import pmsp_pkg::*;

   // =================================================================
   // Types and state.
   typedef enum logic [2:0] {
      PMSP_ST_HUNT  = 3'h0,   // Counting preamble ones.
      PMSP_ST_IDLE  = 3'h1,   // Synchronised, waiting for a start bit.
      PMSP_ST_HEAD  = 3'h2,   // Shifting start, opcode and addresses.
      PMSP_ST_TA    = 3'h3,   // Turnaround bits.
      PMSP_ST_DATA  = 3'h4    // Sixteen data bits.
   } pmsp_dev_state_t;

   pmsp_dev_state_t state_reg, state_next;   // Frame state.
   logic [1:0]  clkSync_reg;                  // Clock synchroniser.
   logic        clkLast_reg;                  // Previous synchronised clock.
   logic [1:0]  datSync_reg;                  // Data synchroniser.
   logic [5:0]  count_reg, count_next;        // Bit counter.
   logic [13:0] head_reg, head_next;          // Start, opcode and address bits.
   logic [15:0] shift_reg, shift_next;        // Data in or out.
   logic        isRead_reg, isRead_next;      // Current frame is an owned read.
   logic        oe_reg, oe_next;              // Line drive enable.
   logic        out_reg, out_next;            // Line drive level.
   logic        wrStb_next;                   // Write strobe next value.
   logic [15:0] regs [NUM_REGS];              // Register space.

   // =================================================================
   // Edge finding on the sampled management clock.
   wire clkS  = clkSync_reg[1];               // Synchronised clock level.
   wire datS  = datSync_reg[1];               // Synchronised data level.
   wire rise  = clkS & ~clkLast_reg;          // Sample point.
   // The register file is read through this helper so the status offset is fixed.
   function automatic logic [15:0] pmsp_rd(input logic [4:0] a, input logic [15:0] v);
      pmsp_rd = (a == BMSTAT_ADDR) ? BMSTAT_RESET : v;
   endfunction : pmsp_rd

   wire [1:0] opSeen  = {head_reg[0], datS};          // Opcode as it completes.
   wire [4:0] devSeen = head_reg[8:4];                 // Device address field.
   wire [4:0] regSeen = {head_reg[3:0], datS};         // Register address as it completes.
   wire       ownDev  = devSeen == DEV_ADDR;

   // Two flip-flops on both link inputs before any logic reads them.
   always_ff @(posedge mclk) begin
      clkSync_reg <= {clkSync_reg[0], link.mgmtClk};
      datSync_reg <= {datSync_reg[0], link.mgmtData};
      clkLast_reg <= clkS;
   end

   // =================================================================
   // Frame decoder, stepping on each rising management clock edge.
   always_comb begin
      state_next  = state_reg;
      count_next  = count_reg;
      head_next   = head_reg;
      shift_next  = shift_reg;
      isRead_next = isRead_reg;
      oe_next     = oe_reg;
      out_next    = out_reg;
      wrStb_next  = 1'b0;
      if (rise) begin
         case (state_reg)
            PMSP_ST_HUNT: begin
               // Count consecutive ones; a zero restarts the count.
               if (!datS) begin
                  count_next = 6'h00;
               end else if (count_reg == 6'(PREAMBLE_LEN - 1)) begin
                  state_next = PMSP_ST_IDLE;
                  count_next = 6'h00;
               end else begin
                  count_next = count_reg + 6'h01;
               end
            end
            PMSP_ST_IDLE: begin
               // A zero is the first start bit; ones are idle or extra preamble.
               if (!datS) begin
                  state_next = PMSP_ST_HEAD;
                  count_next = 6'h00;
                  head_next  = 14'h0000;
               end
            end
            PMSP_ST_HEAD: begin
               // Second start bit, two opcode bits, ten address bits.
               head_next  = {head_reg[12:0], datS};
               count_next = count_reg + 6'h01;
               if (count_reg == 6'h00 && !datS) begin
                  state_next = PMSP_ST_HUNT;
                  count_next = 6'h00;
               end else if (count_reg == 6'h02 && opSeen != OP_READ && opSeen != OP_WRITE) begin
                  state_next = PMSP_ST_HUNT;
                  count_next = 6'h00;
               end else if (count_reg == 6'h0c) begin
                  // Frame header complete; decide ownership of the line.
                  // Twelve bits are in: start one, opcode, device, top of register.
                  isRead_next = head_reg[10:9] == OP_READ && ownDev;
                  shift_next  = pmsp_rd(regSeen, regs[regSeen]);
                  head_next   = {head_reg[12:0], datS};
                  state_next  = PMSP_ST_TA;
                  count_next  = 6'h00;
               end
            end
            PMSP_ST_TA: begin
               count_next = count_reg + 6'h01;
               if (count_reg == 6'h00) begin
                  // First turnaround bit: released on a read, host drives it on a write; device drives zero next.
                  if (head_reg[11:10] == OP_WRITE && !datS) begin
                     // A write turnaround must open with a one.
                     state_next = PMSP_ST_HUNT;
                     count_next = 6'h00;
                  end else if (isRead_reg) begin
                     oe_next  = 1'b1;
                     out_next = 1'b0;
                  end
               end else begin
                  // Write turnaround must read as one then zero.
                  if (head_reg[11:10] == OP_WRITE && datS) begin
                     state_next = PMSP_ST_HUNT;
                     count_next = 6'h00;
                  end else begin
                     state_next = PMSP_ST_DATA;
                     count_next = 6'h00;
                     if (isRead_reg) begin
                        out_next   = shift_reg[15];
                        shift_next = {shift_reg[14:0], 1'b0};
                     end
                  end
               end
            end
            PMSP_ST_DATA: begin
               count_next = count_reg + 6'h01;
               if (isRead_reg) begin
                  out_next   = shift_reg[15];
                  shift_next = {shift_reg[14:0], 1'b0};
               end else begin
                  shift_next = {shift_reg[14:0], datS};
               end
               if (count_reg == 6'(REG_W - 1)) begin
                  // Last data bit: release the line and return to idle.
                  oe_next    = 1'b0;
                  state_next = PMSP_ST_IDLE;
                  count_next = 6'h00;
                  wrStb_next = ~isRead_reg && head_reg[11:10] == OP_WRITE && head_reg[9:5] == DEV_ADDR;
               end
            end
            default: begin
               state_next = PMSP_ST_HUNT;
               oe_next    = 1'b0;
            end
         endcase
      end
   end

   // =================================================================
   // State registers; reset drops synchronisation.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_reg  <= PMSP_ST_HUNT;
         count_reg  <= 6'h00;
         head_reg   <= 14'h0000;
         shift_reg  <= 16'h0000;
         isRead_reg <= 1'b0;
         oe_reg     <= 1'b0;
         out_reg    <= 1'b1;
         wrStrobe   <= 1'b0;
         synced     <= 1'b0;
         wrAddr     <= 5'h00;
         wrData     <= 16'h0000;
      end else begin
         state_reg  <= state_next;
         count_reg  <= count_next;
         head_reg   <= head_next;
         shift_reg  <= shift_next;
         isRead_reg <= isRead_next;
         oe_reg     <= oe_next;
         out_reg    <= out_next;
         wrStrobe   <= wrStb_next;
         synced     <= state_next != PMSP_ST_HUNT;
         if (wrStb_next) begin
            wrAddr <= head_reg[4:0];
            wrData <= shift_next;
         end
      end
   end

   // =================================================================
   // Register space: writable words except the read-only status word.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs[i] <= 16'h0000;
         end
      end else if (wrStb_next && head_reg[4:0] != BMSTAT_ADDR) begin
         regs[head_reg[4:0]] <= shift_next;
      end
   end

   assign link.devDataOe  = oe_reg;
   assign link.devDataOut = out_reg;
endmodule : pmsp_device
`default_nettype wire

// >>> design/pmsp_host.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Host end: makes the management clock and runs frames on command.
module pmsp_host #(
   parameter int HALF_DIV = pmsp_pkg::MDC_DIV  // Half period of the clock in mclk cycles.
) (
   input  wire logic mclk,                  // Local clock.
   input  wire logic rst_b,                 // Synchronous reset, active low.
   pmsp_if.host      link,                  // Management link.
   input  wire logic [3:0]  addr,           // Command register address.
   input  wire logic [31:0] wdata,          // Command write data.
   input  wire logic        wr,             // Write strobe.
   input  wire logic        rd,             // Read strobe.
   output var  logic [31:0] rdata           // Read data, one cycle later.
);
   import pmsp_pkg::*;

   // =================================================================
   // Command registers: 0 control, 4 data, 8 status.
   localparam logic [3:0] CTRL_OFS = 4'h0;  // Write: bit 0 read, bit 1 preamble, [12:8] reg, [20:16] dev.
   localparam logic [3:0] DATA_OFS = 4'h4;  // Write data / read result.
   localparam logic [3:0] STAT_OFS = 4'h8;  // Bit 0 busy.

   logic [63:0] frame_reg;      // Bits to send, MSB first.
   logic [63:0] oeMask_reg;     // Drive enable per bit.
   logic [6:0]  bits_reg;       // Bits left.
   logic [15:0] rx_reg;         // Captured read data.
   logic [7:0]  div_reg;        // Clock divider.
   logic        clk_reg, oe_reg, out_reg;
   wire         busy  = bits_reg != 7'h00;
   wire         start = wr && addr == CTRL_OFS && !busy;
   wire         tick  = div_reg == 8'(HALF_DIV - 1);
   wire         isRd  = wdata[0];
   wire         pre   = wdata[1];
   wire [63:0]  body  = {32'hffffffff, START_CODE, isRd ? OP_READ : OP_WRITE, wdata[20:16],
                         wdata[12:8], isRd ? 2'h3 : TA_WRITE, isRd ? 16'hffff : rx_reg};
   wire [63:0]  mask  = {{32{pre}}, 14'h3fff, isRd ? 18'h00000 : 18'h3ffff};

   // Divider drives the clock; data changes after a falling edge only.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         frame_reg <= 64'h0; oeMask_reg <= 64'h0; bits_reg <= 7'h00;
         rx_reg <= 16'h0000; div_reg <= 8'h00; clk_reg <= 1'b0;
         oe_reg <= 1'b0; out_reg <= 1'b1; rdata <= 32'h0;
      end else begin
         rdata <= addr == DATA_OFS ? {16'h0, rx_reg} : addr == STAT_OFS ? {31'h0, busy} : 32'h0;
         if (wr && addr == DATA_OFS && !busy) rx_reg <= wdata[15:0];
         if (start) begin
            frame_reg <= body; oeMask_reg <= mask;
            bits_reg <= pre ? 7'd65 : 7'd33;         // One trailing idle bit
            div_reg <= 8'h00;
            clk_reg <= 1'b1;  // Each bit opens with a falling edge.
         end else if (busy) begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            if (tick) begin
               clk_reg <= ~clk_reg;
               if (clk_reg) begin
                  // Falling edge: launch the next bit so it is steady at the rise.
                  out_reg <= frame_reg[63];
                  oe_reg <= oeMask_reg[63] && bits_reg != 7'd1;
                  frame_reg <= {frame_reg[62:0], 1'b1};
                  oeMask_reg <= {oeMask_reg[62:0], 1'b0};
               end else begin
                  // Rising edge: sample the line and count the bit.
                  if (bits_reg <= 7'd17 && bits_reg != 7'd1) rx_reg <= {rx_reg[14:0], link.mgmtData};
                  bits_reg <= bits_reg - 7'h01;
               end
            end
         end
         if (!pre && start) begin frame_reg <= body << 32; oeMask_reg <= mask << 32; end
      end
   end

   assign link.mgmtClk     = clk_reg;
   assign link.hostDataOut = out_reg;
   assign link.hostDataOe  = oe_reg;
endmodule : pmsp_host
`default_nettype wire

// >>> dv/pmsp_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Timing and ownership checks on the shared management link.
module pmsp_link_asserts (
   input wire logic mclk,         // Local clock.
   input wire logic rst_b,        // Synchronous reset, active low.
   input wire logic mgmtClk,      // Management clock from the host.
   input wire logic hostDataOut,  // Host data output.
   input wire logic hostDataOe,   // Host output enable.
   input wire logic devDataOut,   // Device data output.
   input wire logic devDataOe,    // Device output enable.
   input wire logic mgmtData      // Resolved line level.
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic [8:0] driveCnt_reg;   // Local cycles the device has driven so far.
   logic [8:0] driveCnt_next;  // Next value of the drive counter.
   // The counter restarts whenever the device lets go of the line.
   assign driveCnt_next = devDataOe ? driveCnt_reg + 9'h001 : 9'h000;
   // The counter register itself.
   always_ff @(posedge mclk) begin
      if (!rst_b) driveCnt_reg <= 9'h000;
      else driveCnt_reg <= driveCnt_next;
   end
   AST_NO_CONTENTION: assert property (!(hostDataOe && devDataOe))
      else $error("Both ends drive the data line.");
   AST_CLK_HIGH: assert property ($rose(mgmtClk) |-> mgmtClk [*4])
      else $error("Management clock high phase too short.");
   AST_CLK_LOW: assert property ($fell(mgmtClk) |-> !mgmtClk [*4])
      else $error("Management clock low phase too short.");
   AST_DEV_STABLE_RISE: assert property ($rose(mgmtClk) |-> $stable(devDataOut) && $stable(devDataOe))
      else $error("Device data moved at a sampling edge.");
   AST_HOST_STABLE_RISE: assert property ($rose(mgmtClk) |-> $stable(hostDataOut) && $stable(hostDataOe))
      else $error("Host data moved at a sampling edge.");
   AST_TA_ZERO: assert property ($rose(devDataOe) |-> !devDataOut)
      else $error("Device turnaround bit is not zero.");
   AST_TA_RELEASED: assert property ($rose(devDataOe) |-> !$past(hostDataOe, 3) && !hostDataOe)
      else $error("Host still drove during first turnaround bit.");
   AST_DRIVE_LEN: assert property ($fell(devDataOe) |-> driveCnt_reg >= 9'h081 && driveCnt_reg <= 9'h088)
      else $error("Device drive did not last seventeen bit times.");
   AST_DEV_STABLE_FALL: assert property ($fell(mgmtClk) && devDataOe |-> $stable(devDataOut))
      else $error("Device data moved in mid bit.");
   AST_IDLE_HIGH: assert property (!hostDataOe && !devDataOe |-> mgmtData)
      else $error("Released line not high.");
endmodule : pmsp_link_asserts
`default_nettype wire

// >>> dv/test_phy_mgmt_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Bench: host and device face each other; a second device faces a bit driver.
module test_phy_mgmt_serial_port;
   import pmsp_pkg::*;
   logic        mclk = 1'b0;     // Local clock.
   logic        rst_b = 1'b0;    // Reset, active low.
   logic [3:0]  hAddr = 4'h0;    // Host command address.
   logic [31:0] hWdata = 32'h0;  // Host command data.
   logic        hWr = 1'b0;      // Host write strobe.
   logic        hRd = 1'b0;      // Host read strobe.
   logic [31:0] hRdata;          // Host read data.
   logic        synced, synced2, wrStrobe;  // Device status outputs.
   logic [4:0]  wrAddr;          // Last written register address.
   logic [15:0] wrData;          // Last written data.
   logic [15:0] mdl [NUM_REGS];  // Model of the register space.
   int          mismatches = 0, n_compared = 0, nStrobe = 0, seed = 32'he1ee;
   logic [15:0] pat [3] = '{16'h0416, 16'h7416, 16'h5414};  // Bad start, opcode, turnaround.
   pmsp_if lk();
   pmsp_if lk2();
   always #2.5 mclk = ~mclk;
   pmsp_host pmsp_host_i (.mclk(mclk), .rst_b(rst_b), .link(lk.host), .addr(hAddr),
      .wdata(hWdata), .wr(hWr), .rd(hRd), .rdata(hRdata));
   pmsp_device pmsp_device_i (.mclk(mclk), .rst_b(rst_b), .link(lk.dev), .synced(synced),
      .wrAddr(wrAddr), .wrData(wrData), .wrStrobe(wrStrobe));
   pmsp_device pmsp_device_i2 (.mclk(mclk), .rst_b(rst_b), .link(lk2.dev), .synced(synced2),
      .wrAddr(), .wrData(), .wrStrobe());
   pmsp_link_asserts pmsp_link_asserts_i (.mclk(mclk), .rst_b(rst_b), .mgmtClk(lk.mgmtClk),
      .hostDataOut(lk.hostDataOut), .hostDataOe(lk.hostDataOe), .devDataOut(lk.devDataOut),
      .devDataOe(lk.devDataOe), .mgmtData(lk.mgmtData));
   // Counts accepted writes; each pulse is one frame.
   always @(posedge mclk) begin
      if (wrStrobe === 1'b1) nStrobe++;
   end
   // Compares one value and reports a mismatch at once.
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Prints the counts and the verdict, then ends the run.
   task test_done;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   // One write cycle on the command port.
   task busW(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      hAddr <= a; hWdata <= d; hWr <= 1'b1;
      @(posedge mclk);
      hWr <= 1'b0;
   endtask : busW
   // One read cycle; data are taken in the following cycle.
   task busR(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      hAddr <= a; hRd <= 1'b1;
      @(posedge mclk);
      hRd <= 1'b0;
      #1 d = hRdata;
   endtask : busR
   // Runs one frame through the host and waits, bounded, until it is idle.
   task frm(input logic rd, input logic pre, input logic [4:0] dv, input logic [4:0] rg,
            input logic [15:0] dt, output logic [15:0] q);
      logic [31:0] s;
      int          n;
      busW(4'h4, {16'h0, dt});
      busW(4'h0, {11'h0, dv, 3'h0, rg, 6'h0, pre, rd});
      n = 0;
      s = 32'h1;
      while (s[0] !== 1'b0 && n < 3000) begin
         busR(4'h8, s);
         n++;
      end
      if (n >= 3000) begin
         mismatches++;
         $display("[ERR] %0t host never went idle", $time);
         test_done();
      end
      busR(4'h4, s);
      q = s[15:0];
   endtask : frm
   // One bit on the second link: 80 ns clock, data changed while the clock is low.
   task bit2(input logic b, input logic oe);
      lk2.hostDataOut <= b;
      lk2.hostDataOe <= oe;
      #40 lk2.mgmtClk <= 1'b1;
      #40 lk2.mgmtClk <= 1'b0;
   endtask : bit2
   // Main sequence.
   initial begin
      logic [15:0] q, d;
      int          r [5] = '{0, 5, 31, 1, 17};
      lk2.mgmtClk = 1'b0; lk2.hostDataOut = 1'b1; lk2.hostDataOe = 1'b0;
      foreach (mdl[i]) mdl[i] = 16'h0;
      mdl[1] = BMSTAT_RESET;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      // Without a preamble the device stays deaf.
      frm(1'b0, 1'b0, 5'h01, 5'h05, 16'h1234, q);
      chk({15'h0, synced}, 16'h0);
      chk(nStrobe[15:0], 16'h0);
      d = 16'($random(seed));
      frm(1'b0, 1'b1, 5'h01, 5'h05, d, q);
      mdl[5] = d;
      chk({15'h0, synced}, 16'h1);
      chk({11'h0, wrAddr}, 16'h5);
      chk(wrData, d);
      // Further frames need no preamble; the status register stays fixed.
      foreach (r[i]) begin
         d = 16'($random(seed));
         frm(1'b0, 1'b0, 5'h01, r[i][4:0], d, q);
         if (r[i] != 1) mdl[r[i]] = d;
      end
      chk(nStrobe[15:0], 16'h6);
      foreach (r[i]) begin
         frm(1'b1, 1'b0, 5'h01, r[i][4:0], 16'h0, q);
         chk(q, mdl[r[i]]);
      end
      frm(1'b1, 1'b0, 5'h01, BMSTAT_ADDR, 16'h0, q);
      chk({15'h0, q[BMSTAT_PS_BIT]}, 16'h1);
      // Another address: no write accepted, the read sees the pull-up.
      frm(1'b0, 1'b0, 5'h02, 5'h05, 16'h0, q);
      frm(1'b1, 1'b0, 5'h02, 5'h05, 16'h0, q);
      chk(q, 16'hffff);
      chk(nStrobe[15:0], 16'h6);
      // Second link: released-line preamble, then each bad field desynchronises.
      chk({15'h0, synced2}, 16'h0);
      foreach (pat[p]) begin
         repeat (32) bit2(1'b1, 1'b0);
         chk({15'h0, synced2}, 16'h1);
         for (int k = 15; k >= 0; k--) bit2(pat[p][k], 1'b1);
         repeat (18) bit2(1'b1, 1'b0);
         chk({15'h0, synced2}, 16'h0);
      end
      test_done();
   end
endmodule : test_phy_mgmt_serial_port
`default_nettype wire
